// >>> inc/smap_cfg.svh
// parameter codes, field encodings and reset values for the servo mode / absolute position block
`ifndef SMAP_CFG_SVH
`define SMAP_CFG_SVH

// ----------------------------------------
// parameter codes (group in high byte, index in low byte)
// ----------------------------------------
`define SMAP_CODE_MOTOR_TYPE 16'h0000
`define SMAP_CODE_CTRL_MODE 16'h0200
`define SMAP_CODE_ABS_SEL 16'h0201
`define SMAP_CODE_ROT_DIR 16'h0202
`define SMAP_CODE_ABS_POS 16'h0B07
`define SMAP_CODE_ABS_RESET 16'h0D14
`define SMAP_CODE_STATUS 16'h0D40

// ----------------------------------------
// control mode selection encoding
// ----------------------------------------
`define SMAP_CM_SPEED 16'h0000
`define SMAP_CM_POSITION 16'h0001
`define SMAP_CM_TORQUE 16'h0002
`define SMAP_CM_TQ_SPD 16'h0003
`define SMAP_CM_SPD_POS 16'h0004
`define SMAP_CM_TQ_POS 16'h0005
`define SMAP_CM_TRIPLE 16'h0006

// ----------------------------------------
// absolute system selection encoding
// ----------------------------------------
`define SMAP_ABS_INCREMENTAL 16'h0000
`define SMAP_ABS_LINEAR 16'h0001
`define SMAP_ABS_ROTATING 16'h0002

// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define SMAP_CTRL_MODE_RST 16'h0001
`define SMAP_ABS_SEL_RST 16'h0000
`define SMAP_ROT_DIR_RST 16'h0000
`define SMAP_ABS_POS_RST 32'h0000_0000
// arbitrary neutral identity values for the two motor types
`define SMAP_MOTOR_ABS_ID 16'hA5A1
`define SMAP_MOTOR_INC_ID 16'hA5A0
`define SMAP_SINGLE_W 23
`define SMAP_MULTI_W 16
`define SMAP_POS_W 39

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define SMAP_ST_BATT 0
`define SMAP_ST_MISMATCH 1
`define SMAP_ST_HOME_REQ 2
`define SMAP_ST_MODE_LSB 4

`endif

// >>> inc/smap_pkg.sv
// types shared by the servo mode / absolute position block
`include "smap_cfg.svh"
package smap_pkg;
  typedef enum logic [1:0] {SMAP_SPEED, SMAP_POSITION, SMAP_TORQUE} smap_mode_e;

  typedef struct packed {
    logic [`SMAP_MULTI_W-1:0] multi;
    logic [`SMAP_SINGLE_W-1:0] single;
  } smap_enc_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] code;
    logic [31:0] wdata;
  } smap_preq_s;
endpackage : smap_pkg

// >>> rtl/smap_mode_sel.sv
// decodes the control mode selection and switch inputs into the working mode
`timescale 1ns/100ps
`include "smap_cfg.svh"
module smap_mode_sel import smap_pkg::*; (
  input wire logic [15:0] sel,
  input wire logic sw_first,
  input wire logic sw_second,
  output smap_mode_e mode
);
  always_comb begin
    unique case (sel)
      `SMAP_CM_SPEED: mode = SMAP_SPEED;
      `SMAP_CM_TORQUE: mode = SMAP_TORQUE;
      `SMAP_CM_TQ_SPD: mode = sw_first ? SMAP_SPEED : SMAP_TORQUE;
      `SMAP_CM_SPD_POS: mode = sw_first ? SMAP_POSITION : SMAP_SPEED;
      `SMAP_CM_TQ_POS: mode = sw_first ? SMAP_POSITION : SMAP_TORQUE;
      `SMAP_CM_TRIPLE: begin
        // both switches together pick one of three modes
        if (sw_second) begin
          mode = SMAP_POSITION;
        end else begin
          mode = sw_first ? SMAP_SPEED : SMAP_TORQUE;
        end
      end
      default: mode = SMAP_POSITION;
    endcase
  end
endmodule : smap_mode_sel

// >>> rtl/smap_top.sv
// servo control mode selection and absolute encoder position handling
`timescale 1ns/100ps
`include "smap_cfg.svh"
module smap_top import smap_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input smap_preq_s preq,
  output logic [31:0] param_rdata,
  input wire logic servo_enable,
  input wire logic servo_running,
  input wire logic mode_switch_first,
  input wire logic mode_switch_second,
  input smap_enc_s enc_pos,
  input wire logic enc_is_absolute,
  input wire logic battery_first_connect,
  input wire logic homing_done,
  input wire logic [`SMAP_POS_W-1:0] nvm_offset_in,
  output logic [1:0] active_mode,
  output logic encoder_battery_fault,
  output logic motor_mismatch_fault,
  output logic homing_required,
  output logic enc_reset_pulse,
  output logic nvm_wr,
  output logic [`SMAP_POS_W-1:0] nvm_wdata
);

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [15:0] ctrl_mode_reg, ctrl_mode_next;
  logic [15:0] motor_type_reg, motor_type_next;
  // the stored selection survives rst, which stands in for a power cycle
  logic [15:0] abs_sel_reg = `SMAP_ABS_SEL_RST;
  logic [15:0] abs_sel_next;
  logic [15:0] rot_dir_reg, rot_dir_next;
  logic [15:0] abs_sel_live_reg, abs_sel_live_next;
  logic boot_reg, boot_next;
  logic wr_ctrl, wr_motor, wr_abs, wr_dir, wr_reset;
  logic stopped;

  assign stopped = !servo_running;
  assign wr_ctrl = preq.wr && preq.code == `SMAP_CODE_CTRL_MODE;
  assign wr_motor = preq.wr && preq.code == `SMAP_CODE_MOTOR_TYPE;
  assign wr_abs = preq.wr && preq.code == `SMAP_CODE_ABS_SEL;
  assign wr_dir = preq.wr && preq.code == `SMAP_CODE_ROT_DIR;
  assign wr_reset = preq.wr && preq.code == `SMAP_CODE_ABS_RESET && preq.wdata[15:0] == 16'h0001;

  always_comb begin
    ctrl_mode_next = ctrl_mode_reg;
    motor_type_next = motor_type_reg;
    abs_sel_next = abs_sel_reg;
    rot_dir_next = rot_dir_reg;
    abs_sel_live_next = abs_sel_live_reg;
    boot_next = 1'b0;
    // out-of-range codes are dropped so the working mode is never undefined
    if (wr_ctrl && stopped && preq.wdata[15:0] <= `SMAP_CM_TRIPLE) begin
      ctrl_mode_next = preq.wdata[15:0];
    end
    if (wr_motor && stopped) begin
      motor_type_next = preq.wdata[15:0];
    end
    if (wr_abs && stopped && preq.wdata[15:0] <= `SMAP_ABS_ROTATING) begin
      abs_sel_next = preq.wdata[15:0];
    end
    if (wr_dir && stopped) begin
      rot_dir_next = {15'h0000, preq.wdata[0]};
    end
    // the selection is only copied into the live one on the first cycle after power-up
    if (boot_reg) begin
      abs_sel_live_next = abs_sel_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_mode_reg <= `SMAP_CTRL_MODE_RST;
      motor_type_reg <= `SMAP_MOTOR_INC_ID;
      rot_dir_reg <= `SMAP_ROT_DIR_RST;
      abs_sel_live_reg <= `SMAP_ABS_SEL_RST;
      boot_reg <= 1'b1;
    end else begin
      ctrl_mode_reg <= ctrl_mode_next;
      motor_type_reg <= motor_type_next;
      rot_dir_reg <= rot_dir_next;
      abs_sel_live_reg <= abs_sel_live_next;
      boot_reg <= boot_next;
    end
  end

  // no reset here: a select written before rst must be the one that goes live after it
  always_ff @(posedge ref_clk) begin
    abs_sel_reg <= abs_sel_next;
  end

  // ----------------------------------------
  // working control mode
  // ----------------------------------------
  smap_mode_e mode_dec;
  smap_mode_e mode_reg, mode_next;

  smap_mode_sel u_mode_sel (
    .sel(ctrl_mode_reg),
    .sw_first(mode_switch_first),
    .sw_second(mode_switch_second),
    .mode(mode_dec)
  );

  always_comb begin
    mode_next = mode_reg;
    // switch inputs are obeyed when enabled and running and also when stopped, where the decoded mode
    // is taken as is; a running drive without enable holds its last working mode
    if (servo_enable && servo_running) begin
      mode_next = mode_dec;
    end else if (!servo_running) begin
      mode_next = mode_dec;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= SMAP_POSITION;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign active_mode = mode_reg;

  // ----------------------------------------
  // faults and homing state
  // ----------------------------------------
  logic batt_reg, batt_next;
  logic mism_reg, mism_next;
  logic home_req_reg, home_req_next;
  logic enc_rst_reg, enc_rst_next;
  logic abs_mode;

  assign abs_mode = abs_sel_live_reg != `SMAP_ABS_INCREMENTAL;

  always_comb begin
    batt_next = batt_reg;
    home_req_next = home_req_reg;
    enc_rst_next = wr_reset;
    if (wr_reset) begin
      batt_next = 1'b0;
    end
    // a new connection in the clearing cycle must not be lost
    if (battery_first_connect) begin
      batt_next = 1'b1;
    end
    if (homing_done) begin
      home_req_next = 1'b0;
    end
    if (wr_reset || (wr_dir && stopped && preq.wdata[0] != rot_dir_reg[0])) begin
      home_req_next = 1'b1;
    end
    mism_next = abs_mode && (!enc_is_absolute || motor_type_reg != `SMAP_MOTOR_ABS_ID);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      batt_reg <= 1'b0;
      mism_reg <= 1'b0;
      home_req_reg <= 1'b0;
      enc_rst_reg <= 1'b0;
    end else begin
      batt_reg <= batt_next;
      mism_reg <= mism_next;
      home_req_reg <= home_req_next;
      enc_rst_reg <= enc_rst_next;
    end
  end

  assign encoder_battery_fault = batt_reg;
  assign motor_mismatch_fault = mism_reg;
  assign homing_required = home_req_reg;
  assign enc_reset_pulse = enc_rst_reg;

  // ----------------------------------------
  // absolute position
  // ----------------------------------------
  logic signed [`SMAP_POS_W-1:0] enc_raw, enc_abs, mech_pos;
  logic [`SMAP_POS_W-1:0] offset_reg, offset_next;
  logic [`SMAP_POS_W-1:0] nvm_data_reg, nvm_data_next;
  logic nvm_wr_reg, nvm_wr_next;
  logic [31:0] abs_cnt_reg, abs_cnt_next;

  assign enc_raw = {enc_pos.multi, enc_pos.single};
  // reversing direction negates the encoder position, which is the step that forces rehoming
  assign enc_abs = rot_dir_reg[0] ? -enc_raw : enc_raw;
  assign mech_pos = enc_abs - $signed(offset_reg);

  always_comb begin
    offset_next = offset_reg;
    nvm_wr_next = 1'b0;
    nvm_data_next = nvm_data_reg;
    if (boot_reg) begin
      offset_next = nvm_offset_in;
    end else if (homing_done) begin
      // home position is mechanical zero, so the offset is the encoder position there
      offset_next = enc_abs;
      nvm_data_next = enc_abs;
      nvm_wr_next = 1'b1;
    end
    abs_cnt_next = abs_mode ? mech_pos[31:0] : `SMAP_ABS_POS_RST;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      offset_reg <= '0;
      nvm_data_reg <= '0;
      nvm_wr_reg <= 1'b0;
      abs_cnt_reg <= `SMAP_ABS_POS_RST;
    end else begin
      offset_reg <= offset_next;
      nvm_data_reg <= nvm_data_next;
      nvm_wr_reg <= nvm_wr_next;
      abs_cnt_reg <= abs_cnt_next;
    end
  end

  assign nvm_wr = nvm_wr_reg;
  assign nvm_wdata = nvm_data_reg;

  // ----------------------------------------
  // parameter read back
  // ----------------------------------------
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`SMAP_ST_BATT] = batt_reg;
    status_word[`SMAP_ST_MISMATCH] = mism_reg;
    status_word[`SMAP_ST_HOME_REQ] = home_req_reg;
    status_word[`SMAP_ST_MODE_LSB +: 2] = mode_reg;
    rdata_next = rdata_reg;
    if (preq.rd) begin
      unique case (preq.code)
        `SMAP_CODE_CTRL_MODE: rdata_next = {16'h0000, ctrl_mode_reg};
        `SMAP_CODE_MOTOR_TYPE: rdata_next = {16'h0000, motor_type_reg};
        `SMAP_CODE_ABS_SEL: rdata_next = {16'h0000, abs_sel_reg};
        `SMAP_CODE_ROT_DIR: rdata_next = {16'h0000, rot_dir_reg};
        `SMAP_CODE_ABS_POS: rdata_next = abs_cnt_reg;
        `SMAP_CODE_STATUS: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign param_rdata = rdata_reg;

endmodule : smap_top

// >>> test/smap_properties.sv
// port checker for the servo mode and absolute position block
`timescale 1ns/100ps
`include "smap_cfg.svh"
module smap_props import smap_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input smap_preq_s preq,
  input wire logic servo_enable,
  input wire logic servo_running,
  input wire logic battery_first_connect,
  input wire logic homing_done,
  input wire logic [1:0] active_mode,
  input wire logic encoder_battery_fault,
  input wire logic homing_required,
  input wire logic enc_reset_pulse,
  input wire logic nvm_wr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // --------
  // mode hold, mode encoding, battery fault, encoder reset and homing steps
  // --------
  wire clr = preq.wr && preq.code == `SMAP_CODE_ABS_RESET && preq.wdata[15:0] == 16'h0001;
  sequence s_clr;
    !encoder_battery_fault && enc_reset_pulse && homing_required ##1 !enc_reset_pulse;
  endsequence
  sequence s_home;
    nvm_wr && !homing_required ##1 !nvm_wr;
  endsequence
  property p_hold; servo_running && !servo_enable |=> $stable(active_mode); endproperty
  a_hold: assert property (p_hold) else $error("mode moved while held");
  property p_enum; active_mode != 2'h3; endproperty
  a_enum: assert property (p_enum) else $error("unused mode code");
  property p_set; battery_first_connect |=> encoder_battery_fault; endproperty
  a_set: assert property (p_set) else $error("battery fault not raised");
  property p_keep; encoder_battery_fault && !clr |=> encoder_battery_fault; endproperty
  a_keep: assert property (p_keep) else $error("battery fault dropped");
  property p_clr; clr && !battery_first_connect && !homing_done |=> s_clr; endproperty
  a_clr: assert property (p_clr) else $error("encoder reset effect wrong");
  property p_cause; enc_reset_pulse |-> $past(clr); endproperty
  a_cause: assert property (p_cause) else $error("stray encoder reset");
  property p_home; homing_done && !clr |=> s_home; endproperty
  a_home: assert property (p_home) else $error("homing store wrong");
  property p_nvm; nvm_wr |-> $past(homing_done); endproperty
  a_nvm: assert property (p_nvm) else $error("stray offset store");
endmodule : smap_props
bind smap_top smap_props u_props (.ref_clk, .rst, .preq, .servo_enable, .servo_running, .battery_first_connect,
  .homing_done, .active_mode, .encoder_battery_fault, .homing_required, .enc_reset_pulse, .nvm_wr);

// >>> test/smap_host.sv
// host controller model that drives the mode switch inputs
`timescale 1ns/100ps
module smap_host (
  input wire logic ref_clk,
  input wire logic [2:0] cm,
  input wire logic [1:0] want,
  output logic mode_switch_first,
  output logic mode_switch_second
);
  // --------
  // switch drive
  // --------
  initial {mode_switch_first, mode_switch_second} = 2'b00;
  // the second input only has a function in the triple mode, so elsewhere it idles low
  always @(posedge ref_clk) begin
    mode_switch_first <= want[0];
    mode_switch_second <= (cm == 3'h6) ? want[1] : 1'b0;
  end
endmodule : smap_host

// >>> test/smap_top_test.sv
// self-checking bench for the servo mode and absolute position block
`timescale 1ns/100ps
`include "smap_cfg.svh"
module smap_top_test import smap_pkg::*;;
  localparam logic [15:0] k_ctl = `SMAP_CODE_CTRL_MODE;
  localparam logic [15:0] k_asl = `SMAP_CODE_ABS_SEL;
  localparam logic [15:0] k_pos = `SMAP_CODE_ABS_POS;
  localparam logic [15:0] k_ars = `SMAP_CODE_ABS_RESET;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  smap_preq_s preq = '0;
  smap_enc_s enc_pos = '0;
  logic servo_enable = 1'b0, servo_running = 1'b0, enc_is_absolute = 1'b0;
  logic battery_first_connect = 1'b0, homing_done = 1'b0;
  logic [38:0] nvm_offset_in, nvm_wdata, e;
  logic [63:0] r;
  logic [31:0] param_rdata, d;
  logic [2:0] cm = 3'h1;
  logic [1:0] want = 2'h0, active_mode;
  logic encoder_battery_fault, motor_mismatch_fault, homing_required, enc_reset_pulse, nvm_wr;
  logic mode_switch_first, mode_switch_second;
  int num_errors = 0, comparisons = 0, cycles = 0, seed = 13889, em = 1;

  smap_top DUT (.ref_clk, .rst, .preq, .param_rdata, .servo_enable, .servo_running, .mode_switch_first,
    .mode_switch_second, .enc_pos, .enc_is_absolute, .battery_first_connect, .homing_done, .nvm_offset_in,
    .active_mode, .encoder_battery_fault, .motor_mismatch_fault, .homing_required, .enc_reset_pulse,
    .nvm_wr, .nvm_wdata);
  smap_host u_host (.ref_clk, .cm, .want, .mode_switch_first, .mode_switch_second);

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  // --------
  // helpers
  // --------
  function automatic int exp_mode(int c, int s1, int s2);
    case (c)
      0, 1, 2: return c;
      3: return s1 ? 0 : 2;
      4: return s1 ? 1 : 0;
      5: return s1 ? 1 : 2;
      default: return s2 ? 1 : (s1 ? 0 : 2);
    endcase
  endfunction : exp_mode
  task automatic chk(string n, logic [38:0] x, logic [38:0] g);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(logic [15:0] c, logic [15:0] v);
    @(posedge ref_clk) preq <= '{1'b1, 1'b0, c, {16'h0000, v}};
    @(posedge ref_clk) preq <= '0;
  endtask : wr
  task automatic rd(logic [15:0] c);
    @(posedge ref_clk) preq <= '{1'b0, 1'b1, c, 32'h0000_0000};
    @(posedge ref_clk) preq <= '0;
    #1 d = param_rdata;
  endtask : rd
  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // --------
  // scenarios
  // --------
  initial begin
    r = {$random(seed), $random(seed)};
    nvm_offset_in = r[38:0];
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk("mode", 1, active_mode);
    chk("flags", 0, {encoder_battery_fault, motor_mismatch_fault, homing_required, nvm_wr});
    rd(k_ctl);
    chk("ctrl", 1, d);
    rd(k_pos);
    chk("count", 0, d);
    rd(16'h0FFF);
    chk("unmapped", 0, d);
    // code 7 is out of range and must leave the last good code in place
    for (int m = 0; m < 8; m++) begin
      wr(k_ctl, 16'(m));
      if (m < 7) em = m;
      cm <= 3'(em);
      for (int k = 0; k < 4; k++) begin
        want <= 2'($random(seed));
        tick(3);
        chk("mode", exp_mode(em, mode_switch_first, mode_switch_second), active_mode);
      end
    end
    rd(k_ctl);
    chk("ctrl", 6, d);
    wr(k_ctl, 16'h0004);
    cm <= 3'h4;
    @(posedge ref_clk) {servo_enable, servo_running} <= 2'b11;
    for (int k = 0; k < 4; k++) begin
      if (k == 2) @(posedge ref_clk) servo_enable <= 1'b0;
      want <= 2'(k);
      tick(3);
      chk("run_mode", k == 0 ? 0 : 1, active_mode);
    end
    wr(k_ctl, 16'h0000);
    rd(k_ctl);
    chk("ctrl_run", 4, d);
    @(posedge ref_clk) servo_running <= 1'b0;
    wr(k_asl, 16'h0003);
    rd(k_asl);
    chk("abs_sel", 0, d);
    wr(k_asl, 16'h0001);
    rd(k_asl);
    chk("abs_sel", 1, d);
    chk("mismatch", 0, motor_mismatch_fault);
    // power cycle: the new absolute select and the stored offset only count from here
    r = {$random(seed), $random(seed)};
    @(posedge ref_clk) begin
      enc_pos <= r[38:0];
      rst <= 1'b1;
    end
    @(posedge ref_clk) rst <= 1'b0;
    tick(2);
    chk("mismatch", 1, motor_mismatch_fault);
    wr(`SMAP_CODE_MOTOR_TYPE, `SMAP_MOTOR_ABS_ID);
    @(posedge ref_clk) enc_is_absolute <= 1'b1;
    tick(2);
    chk("mismatch", 0, motor_mismatch_fault);
    e = r[38:0] - nvm_offset_in;
    rd(k_pos);
    chk("count", e[31:0], d);
    wr(k_pos, 16'h1234);
    rd(k_pos);
    chk("count_ro", e[31:0], d);
    @(posedge ref_clk) battery_first_connect <= 1'b1;
    @(posedge ref_clk) battery_first_connect <= 1'b0;
    #1 chk("batt", 1, encoder_battery_fault);
    rd(`SMAP_CODE_STATUS);
    chk("status", 1, d[0]);
    wr(k_ars, 16'h0002);
    #1 chk("batt", 1, encoder_battery_fault);
    wr(k_ars, 16'h0001);
    #1 chk("clear", 3'b011, {encoder_battery_fault, enc_reset_pulse, homing_required});
    r = {$random(seed), $random(seed)};
    @(posedge ref_clk) begin
      enc_pos <= r[38:0];
      homing_done <= 1'b1;
    end
    @(posedge ref_clk) homing_done <= 1'b0;
    #1 chk("nvm_wr", 2'b10, {nvm_wr, homing_required});
    chk("nvm_data", r[38:0], nvm_wdata);
    e = r[38:0];
    @(posedge ref_clk) enc_pos <= e + 39'(r[63:50]);
    rd(k_pos);
    chk("count", 32'(r[63:50]), d);
    wr(`SMAP_CODE_ROT_DIR, 16'h0001);
    tick(1);
    chk("rehome", 1, homing_required);
    rd(k_pos);
    e = 39'h0 - enc_pos - e;
    chk("count_dir", e[31:0], d);
    give_verdict();
  end
endmodule : smap_top_test
